// ==== sew_pkg.sv ====
package sew_pkg;

	// array and page geometry
	localparam int ADDR_W     = 16;
	localparam int OFF_W      = 7;
	localparam int PAGE_BYTES = 128;

	// device type codes in the upper nibble of the address byte
	localparam logic [3:0] TYPE_ARRAY = 4'ha;
	localparam logic [3:0] TYPE_IDENT = 4'hb;

	// word address bits 11:9, which sit in bits 3:1 of the first byte
	localparam int         SEL_LSB    = 1;
	localparam int         SEL_MSB    = 3;
	localparam logic [2:0] IDSEL_PAGE = 3'h0;
	localparam logic [2:0] IDSEL_LOCK = 3'h2;

	// freeze command data bit, direction bit value for a write
	localparam int   LOCK_BIT  = 1;
	localparam logic DIR_WRITE = 1'b0;

	// bit slots within one byte frame
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST  = 4'h8;
	localparam logic [3:0] ACK_SLOT  = 4'h9;
	// the tenth clock's rise has already counted one slot by the stop
	localparam logic [3:0] STOP_SLOT = 4'h1;

	// program cycle time, longest figure rounded down to whole cycles
	localparam int CLK_KHZ     = 20000;
	localparam int T_WR_US     = 3000;
	localparam int T_WR_CYCLES = (T_WR_US * CLK_KHZ) / 1000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_DATA,
		ST_PROG
	} sew_state_t;

endpackage : sew_pkg

// ==== sew_sync.sv ====
`timescale 1ns/1ps

// two-stage synchroniser; only the second stage leaves this module
module sew_sync #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// reset to the idle level so release makes no false edges
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : sew_sync

// ==== sew_top.sv ====
// Behaviour
// - start, type code 1010 with write bit, acked; both word address bytes acked
// - guard pin high nacks byte-write data and keeps location unchanged
// - byte write programs only on stop in the tenth clock
// - program cycle ignores all inputs, ends within program_cycle_time
// - internal address counter advances once per written byte
// - page write keeps sending bytes, at most 128 held per cycle
// - page write acks each byte while guard low, none while high
// - page write programs only on stop right after last ack
// - only low seven address bits increment, wrapping inside the page
// - beyond 128 bytes later data overwrites earlier bytes of the page
// - busy lasts from valid stop to the end of the program cycle
// - address byte nacked while programming, acked once finished
// - ident_page write uses type 1011, bits 11:9 zero, 7-bit offset
// - locked ident_page nacks its data bytes and stays unchanged
// - page_freeze_command is 1011, bits 11:9 010, data bit 1 set
// - after freezing, later page_freeze_command data bytes are nacked
// - select bits compared with straps; mismatch nacks and goes standby
// - guard pin high also blocks ident_page writes
// - bytes travel msb first, bit 0 low selects a write
`timescale 1ns/1ps

module sew_top
	import sew_pkg::*;
#(
	parameter int WRITE_CYCLES = T_WR_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              select_strap_2,
	input  wire logic              select_strap_1,
	input  wire logic              select_strap_0,
	input  wire logic              write_guard,
	output logic                   mem_we,
	output logic                   mem_ident,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [7:0]        mem_wdata,
	output logic                   busy,
	output logic                   ident_locked
);

	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_PAGE = CNT_W'(PAGE_BYTES);

	// the walk over the page buffer must fit inside the cycle
	if (WRITE_CYCLES <= PAGE_BYTES) begin : g_bad_cycles
		$error("WRITE_CYCLES must exceed the page size");
	end

	// pins from outside the clock domain
	logic       scl_s;
	logic       sda_s;
	logic       wp_s;
	logic [2:0] strap_s;

	sew_sync #(.W(2), .RST(2'h3)) u_sync_bus (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({scl_in, sda_in}),
		.q        ({scl_s, sda_s})
	);

	sew_sync #(.W(4), .RST(4'h0)) u_sync_pins (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({write_guard, select_strap_2, select_strap_1,
		            select_strap_0}),
		.q        ({wp_s, strap_s})
	);

	sew_state_t              state_q;
	logic                    scl_prev_q;
	logic                    sda_prev_q;
	logic       [3:0]        bit_cnt_q;
	logic       [7:0]        shift_q;
	logic       [7:0]        hi_q;
	logic                    ident_q;
	logic       [ADDR_W-1:0] addr_q;
	logic                    got_q;
	logic                    lock_pend_q;
	logic                    locked_q;
	logic       [PAGE_BYTES-1:0] vld_q;
	logic       [7:0]        buf_q [PAGE_BYTES];
	logic       [CNT_W-1:0]  prog_cnt_q;
	logic       [CNT_W-1:0]  busy_len_q;
	logic                    busy_q;
	logic                    sda_oe_q;
	logic                    sda_out_q;
	logic                    mem_we_q;
	logic                    mem_ident_q;
	logic       [ADDR_W-1:0] mem_addr_q;
	logic       [7:0]        mem_wdata_q;

	// bus events seen on the synchronised lines
	wire scl_rise = scl_s & ~scl_prev_q;
	wire scl_fall = ~scl_s & scl_prev_q;
	wire ev_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	wire ev_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	wire in_prog  = (state_q == ST_PROG);
	wire bit_in   = scl_rise && (bit_cnt_q < BIT_LAST) && !in_prog;
	wire byte_done = scl_fall && (bit_cnt_q == BIT_LAST) && !in_prog;
	wire ack_end  = scl_fall && (bit_cnt_q == ACK_SLOT) && !in_prog;

	// address byte decode, msb first with direction in bit 0
	wire [3:0] type_code = shift_q[7:4];
	wire type_ok   = (type_code == TYPE_ARRAY) || (type_code == TYPE_IDENT);
	wire dev_match = type_ok && (shift_q[3:1] == strap_s)
	                 && (shift_q[0] == DIR_WRITE);

	// what the stored word address selects
	wire [2:0] id_sel = hi_q[SEL_MSB:SEL_LSB];
	wire is_ident_page   = ident_q && (id_sel == IDSEL_PAGE);
	wire is_freeze    = ident_q && (id_sel == IDSEL_LOCK);
	wire freeze_ok    = is_freeze && !locked_q && shift_q[LOCK_BIT]
	                    && !got_q;
	wire page_ok      = !ident_q || (is_ident_page && !locked_q);
	wire data_ok      = !wp_s && (page_ok || freeze_ok);

	// ack decision and next state at the end of each byte
	logic       ack_now;
	sew_state_t nxt_state;
	always_comb begin
		ack_now   = 1'b0;
		nxt_state = ST_IDLE;
		unique case (state_q)
			ST_DEV: begin
				ack_now   = dev_match;
				nxt_state = dev_match ? ST_AHI : ST_IDLE;
			end
			ST_AHI: begin
				ack_now   = 1'b1;
				nxt_state = ST_ALO;
			end
			ST_ALO: begin
				ack_now   = 1'b1;
				nxt_state = ST_DATA;
			end
			ST_DATA: begin
				ack_now   = data_ok;
				nxt_state = ST_DATA;
			end
			ST_IDLE, ST_PROG: begin
				ack_now   = 1'b0;
				nxt_state = state_q;
			end
		endcase
	end

	wire take     = byte_done && (state_q == ST_DATA) && data_ok;
	wire take_buf = take && !freeze_ok;
	// stop counts only in the clock right after a data byte's ack slot, once a data byte of the transfer was acked
	wire stop_ok  = ev_stop && (state_q == ST_DATA) && got_q
	                && (bit_cnt_q == STOP_SLOT);
	wire cnt_done = (prog_cnt_q == CNT_LAST);
	wire [OFF_W-1:0] walk_idx = prog_cnt_q[OFF_W-1:0];
	wire walk_we  = in_prog && (prog_cnt_q < CNT_PAGE) && vld_q[walk_idx];
	wire [OFF_W-1:0] next_off = addr_q[OFF_W-1:0] + OFF_W'(1);

	// line history for edge and condition detection
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// protocol state; the program cycle sees no bus event at all
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
		end else if (in_prog) begin
			state_q <= cnt_done ? ST_IDLE : ST_PROG;
		end else if (ev_start) begin
			state_q <= ST_DEV;
		end else if (ev_stop) begin
			state_q <= stop_ok ? ST_PROG : ST_IDLE;
		end else if (byte_done) begin
			state_q <= nxt_state;
		end
	end

	// bit slot counter and msb-first shift register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			bit_cnt_q <= BIT_FIRST;
			shift_q   <= 8'h00;
		end else if (in_prog || ev_start || ev_stop || ack_end) begin
			bit_cnt_q <= BIT_FIRST;
		end else if (bit_in) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q   <= {shift_q[6:0], sda_s};
		end else if (byte_done) begin
			bit_cnt_q <= ACK_SLOT;
		end
	end

	// acknowledge driver: pulled low for the whole ninth clock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sda_oe_q  <= 1'b0;
			sda_out_q <= 1'b0;
		end else if (in_prog || ev_start || ev_stop || ack_end) begin
			sda_oe_q  <= 1'b0;
		end else if (byte_done) begin
			sda_oe_q  <= ack_now;
		end
	end

	// word address capture and in-page counter
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hi_q    <= 8'h00;
			ident_q <= 1'b0;
			addr_q  <= '0;
		end else if (byte_done && state_q == ST_DEV) begin
			ident_q <= (type_code == TYPE_IDENT);
		end else if (byte_done && state_q == ST_AHI) begin
			hi_q <= shift_q;
		end else if (byte_done && state_q == ST_ALO) begin
			addr_q <= {hi_q, shift_q};
		end else if (take) begin
			// upper bits hold the page row, low bits wrap
			addr_q <= {addr_q[ADDR_W-1:OFF_W], next_off};
		end
	end

	// accepted bytes and pending freeze; a new start outside the program cycle drops them
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			got_q       <= 1'b0;
			lock_pend_q <= 1'b0;
			vld_q       <= '0;
		end else if (ev_start && !in_prog) begin
			got_q       <= 1'b0;
			lock_pend_q <= 1'b0;
			vld_q       <= '0;
		end else if (in_prog && cnt_done) begin
			got_q       <= 1'b0;
			lock_pend_q <= 1'b0;
			vld_q       <= '0;
		end else if (take) begin
			got_q <= 1'b1;
			if (freeze_ok) begin
				lock_pend_q <= 1'b1;
			end else begin
				vld_q[addr_q[OFF_W-1:0]] <= 1'b1;
			end
		end
	end

	// page buffer; a rewrite of the same offset replaces older data
	always_ff @(posedge core_clk) begin
		if (take_buf) begin
			buf_q[addr_q[OFF_W-1:0]] <= shift_q;
		end
	end

	// freeze bit; held only while powered
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			locked_q <= 1'b0;
		end else if (in_prog && cnt_done && lock_pend_q) begin
			locked_q <= 1'b1;
		end
	end

	// self-timed cycle: walk the buffer, then wait out the time
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prog_cnt_q  <= '0;
			mem_we_q    <= 1'b0;
			mem_ident_q <= 1'b0;
			mem_addr_q  <= '0;
			mem_wdata_q <= 8'h00;
			busy_q      <= 1'b0;
		end else begin
			mem_we_q <= walk_we;
			busy_q   <= in_prog;
			if (walk_we) begin
				mem_ident_q <= ident_q;
				mem_addr_q  <= {addr_q[ADDR_W-1:OFF_W], walk_idx};
				mem_wdata_q <= buf_q[walk_idx];
			end
			prog_cnt_q <= (in_prog && !cnt_done) ?
			              prog_cnt_q + CNT_W'(1) : '0;
		end
	end

	assign sda_oe       = sda_oe_q;
	assign sda_out      = sda_out_q;
	assign mem_we       = mem_we_q;
	assign mem_ident    = mem_ident_q;
	assign mem_addr     = mem_addr_q;
	assign mem_wdata    = mem_wdata_q;
	assign busy         = busy_q;
	assign ident_locked = locked_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	busy_silent_a: assert property (in_prog |-> !sda_oe_q)
		else $error("ack driven during program cycle");

	poll_nack_a: assert property (
		in_prog ##1 !in_prog |-> !sda_oe_q [*2])
		else $error("bus driven at program end");

	guard_nack_a: assert property (
		byte_done && state_q == ST_DATA && wp_s |=> !sda_oe_q)
		else $error("data acked with guard high");

	guard_keep_a: assert property (wp_s && byte_done |-> !take)
		else $error("byte taken with guard high");

	stop_prog_a: assert property (stop_ok |=> in_prog)
		else $error("valid stop did not start programming");

	bad_stop_a: assert property (
		ev_stop && !stop_ok && !in_prog |=> !in_prog)
		else $error("misplaced stop started programming");

	page_wrap_a: assert property (take |=>
		addr_q[OFF_W-1:0] == $past(addr_q[OFF_W-1:0]) + OFF_W'(1)
		&& addr_q[ADDR_W-1:OFF_W] == $past(addr_q[ADDR_W-1:OFF_W]))
		else $error("address not wrapped within page");

	dev_ack_a: assert property (
		byte_done && state_q == ST_DEV |=> sda_oe_q == $past(dev_match))
		else $error("address byte answer wrong");

	freeze_nack_a: assert property (locked_q && byte_done
		&& state_q == ST_DATA && ident_q |=> !sda_oe_q)
		else $error("frozen page data acked");

	// busy length counted here; the limit is far too long to unroll
	always_ff @(posedge core_clk) begin
		busy_len_q <= (rstn && in_prog) ? busy_len_q + CNT_W'(1) : '0;
	end

	prog_len_a: assert property (in_prog |-> busy_len_q <= CNT_LAST)
		else $error("program cycle overran");

	write_busy_a: assert property (mem_we_q |-> $past(in_prog))
		else $error("array written outside program cycle");

	byte_prog_c: cover property (stop_ok && ident_q == 1'b0);
	page_wrap_c: cover property (take && addr_q[OFF_W-1:0] == '1);
	freeze_c:    cover property ($rose(locked_q));
	poll_c:      cover property (in_prog && ev_start);

endmodule : sew_top

// ==== sew_master.sv ====
`timescale 1ns/1ps

// bus controller model; scl stands high between frames
module sew_master (
	input  wire logic core_clk,
	input  wire logic sda_oe,
	input  wire logic sda_out,
	output logic      scl_in,
	output logic      sda_in
);
	logic drv_q;

	// open-drain wire with pull-up: released reads high, else drive level
	assign sda_in = drv_q & (sda_oe ? sda_out : 1'b1);

	initial begin
		scl_in = 1'b1;
		drv_q  = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wait_clk

	// start from idle or as a repeated start after a byte
	task automatic start();
		drv_q = 1'b1;
		wait_clk(2);
		scl_in = 1'b1;
		wait_clk(4);
		drv_q = 1'b0;
		wait_clk(4);
		scl_in = 1'b0;
	endtask : start

	// top n bits of b, msb first, 8 core_clk per scl period
	task automatic bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			wait_clk(2);
			drv_q = b[i];
			wait_clk(2);
			scl_in = 1'b1;
			wait_clk(4);
			scl_in = 1'b0;
		end
	endtask : bits

	// whole byte plus the ninth clock, ack sampled mid-high
	task automatic send_byte(input logic [7:0] b, output logic ack);
		bits(b, 8);
		wait_clk(2);
		drv_q = 1'b1;
		wait_clk(2);
		scl_in = 1'b1;
		wait_clk(2);
		ack = ~sda_in;
		wait_clk(2);
		scl_in = 1'b0;
	endtask : send_byte

	// stop in the clock right after the last ack
	task automatic stop();
		wait_clk(2);
		drv_q = 1'b0;
		wait_clk(2);
		scl_in = 1'b1;
		wait_clk(4);
		drv_q = 1'b1;
		wait_clk(4);
	endtask : stop
endmodule : sew_master

// ==== serial_eeprom_write_path_bench.sv ====
`timescale 1ns/1ps

module serial_eeprom_write_path_bench
	import sew_pkg::*;
;
	logic              core_clk;
	logic              rstn;
	logic              scl_in;
	logic              sda_in;
	logic              sda_out;
	logic              sda_oe;
	logic [2:0]        strap;
	logic              write_guard;
	logic              mem_we;
	logic              mem_ident;
	logic [ADDR_W-1:0] mem_addr;
	logic [7:0]        mem_wdata;
	logic              busy;
	logic              ident_locked;
	logic [24:0]       expq[$];
	logic [31:0]       seed;
	logic              ack;
	int                mismatches;
	int                comparisons;
	int                cycles;

	sew_top #(.WRITE_CYCLES(200)) dut (
		.core_clk(core_clk), .rstn(rstn), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.select_strap_2(strap[2]), .select_strap_1(strap[1]),
		.select_strap_0(strap[0]), .write_guard(write_guard),
		.mem_we(mem_we), .mem_ident(mem_ident), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .busy(busy), .ident_locked(ident_locked)
	);

	sew_master m (
		.core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out),
		.scl_in(scl_in), .sda_in(sda_in)
	);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [24:0] got, input logic [24:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// every written byte is checked against the oldest note, mid-cycle
	always @(negedge core_clk) begin
		if (rstn === 1'b1 && mem_we === 1'b1) begin
			if (expq.size() == 0) check(25'h1, 25'h0);
			else check({mem_ident, mem_addr, mem_wdata}, expq.pop_front());
		end
	end

	// hang guard, about four times the roughly fifteen thousand cycles used
	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 60000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic header(input logic [3:0] t, input logic [15:0] a);
		m.start();
		m.send_byte({t, strap, DIR_WRITE}, ack);
		check(25'(ack), 25'h1);
		m.send_byte(a[15:8], ack);
		check(25'(ack), 25'h1);
		m.send_byte(a[7:0], ack);
		check(25'(ack), 25'h1);
	endtask : header

	// polls once while busy, waits for the end, then polls again
	task automatic wait_prog();
		int n;
		check(25'(busy), 25'h1);
		m.start();
		m.send_byte({TYPE_ARRAY, strap, DIR_WRITE}, ack);
		check(25'(ack), 25'h0);
		m.stop();
		n = 0;
		while (busy === 1'b1 && n < 400) begin
			m.wait_clk(1);
			n++;
		end
		check(25'(busy), 25'h0);
		m.start();
		m.send_byte({TYPE_ARRAY, strap, DIR_WRITE}, ack);
		check(25'(ack), 25'h1);
		m.stop();
	endtask : wait_prog

	// n random bytes from a; notes the writes in offset order, last wins
	task automatic page(input logic [3:0] t, input logic [15:0] a,
			input int n, input logic ok);
		logic [7:0] val[128];
		logic       vld[128];
		logic [6:0] k;
		logic [7:0] d;
		for (int i = 0; i < 128; i++) vld[i] = 1'b0;
		header(t, a);
		k = a[6:0];
		repeat (n) begin
			d = 8'(xs());
			m.send_byte(d, ack);
			check(25'(ack), 25'(ok));
			val[k] = d;
			vld[k] = 1'b1;
			k++;
		end
		m.stop();
		if (ok) begin
			for (int i = 0; i < 128; i++) begin
				if (vld[i]) expq.push_back({t == TYPE_IDENT, a[15:7], 7'(i), val[i]});
			end
			wait_prog();
		end else begin
			m.wait_clk(8);
			check(25'(busy), 25'h0);
		end
	endtask : page

	task automatic freeze(input logic [7:0] d, input logic ok);
		header(TYPE_IDENT, {4'h0, IDSEL_LOCK, 9'h000});
		m.send_byte(d, ack);
		check(25'(ack), 25'(ok));
		m.stop();
		if (ok) wait_prog();
		else m.wait_clk(8);
	endtask : freeze

	initial begin
		logic [31:0] r;
		logic [7:0]  bad[3];
		rstn = 1'b0;
		write_guard = 1'b0;
		seed = 32'd80846;
		r = xs();
		strap = r[2:0];
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		repeat (20) @(negedge core_clk);
		rstn = 1'b1;
		m.wait_clk(4);
		// wrong straps, read direction, wrong type: all refused
		bad[0] = {TYPE_ARRAY, strap ^ 3'h1, DIR_WRITE};
		bad[1] = {TYPE_ARRAY, strap, ~DIR_WRITE};
		bad[2] = {4'h9, strap, DIR_WRITE};
		foreach (bad[i]) begin
			m.start();
			m.send_byte(bad[i], ack);
			check(25'(ack), 25'h0);
			m.stop();
		end
		r = xs();
		page(TYPE_ARRAY, r[15:0], 1, 1'b1);
		write_guard = 1'b1;
		m.wait_clk(4);
		page(TYPE_ARRAY, r[31:16], 1, 1'b0);
		page(TYPE_ARRAY, r[15:0], 3, 1'b0);
		page(TYPE_IDENT, 16'hf07d, 2, 1'b0);
		write_guard = 1'b0;
		// every strap takes its other level for the rest of the run
		strap = ~strap;
		m.wait_clk(4);
		// more than a page from offset 7e: wraps and overwrites
		r = xs();
		page(TYPE_ARRAY, {r[8:0], 7'h7e}, 130, 1'b1);
		// stop inside a data byte aborts the write
		header(TYPE_ARRAY, r[15:0]);
		m.send_byte(8'h5a, ack);
		check(25'(ack), 25'h1);
		m.bits(8'hff, 3);
		m.stop();
		m.wait_clk(8);
		check(25'(busy), 25'h0);
		page(TYPE_IDENT, 16'hf07d, 5, 1'b1);
		page(TYPE_IDENT, 16'h0210, 1, 1'b0);
		freeze(8'hfd, 1'b0);
		check(25'(ident_locked), 25'h0);
		freeze(8'h02, 1'b1);
		check(25'(ident_locked), 25'h1);
		page(TYPE_IDENT, 16'h0010, 2, 1'b0);
		freeze(8'hff, 1'b0);
		check(25'(expq.size()), 25'h0);
		test_done();
	end
endmodule : serial_eeprom_write_path_bench
